// file: sflash_host.sv
// Host model: drives select, serial clock and data for one-lane frames.
// Assumes mode 0 at 800 ns a bit; serial clock rests low between frames.
`timescale 1ns/10ps
module sflash_host (
	input wire logic clk,
	output logic cs_n,
	output logic sclk,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	// ------------------------------------------------------------
	// Frame engine
	// ------------------------------------------------------------
	logic [7:0] rd_q;
	event rd_ev;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
		rd_q = 8'h00;
	end
	// Counts other than 8 or 16 only when a test asks for them
	task automatic xfer(input logic [7:0] op, input logic [15:0] d, input int n);
		logic [23:0] w;
		logic oe;
		w = {op, d};
		oe = 1'b0;
		@(posedge clk);
		#1 cs_n = 1'b0;
		for (int i = 0; i < 8 + n; i++) begin
			si = w[23];
			w = w << 1;
			repeat (4) @(posedge clk);
			#1 sclk = 1'b1;
			repeat (4) @(posedge clk);
			#1 rd_q = {rd_q[6:0], so};
			oe = oe | so_oe;
			sclk = 1'b0;
		end
		repeat (4) @(posedge clk);
		#1 cs_n = 1'b1;
		// Released line shows the inverse, never a stale level
		si = ~si;
		if (oe) begin
			-> rd_ev;
		end
		repeat (10) @(posedge clk);
	endtask : xfer
endmodule : sflash_host

// file: sflash_pkg.sv
// Constants, field layout and state encoding of the flash status/setup register logic.
// Assumes a single 10 MHz core clock; the serial link is sampled, not clocked.
//
// Summary of operation
// - Write-regs updates lock, four-lane and protect bits, never latch or active flags.
// - Pin lock mode refuses write-regs; register contents stay unchanged.
// - Select must rise after exactly 8 or 16 data bits, else no write.
// - Self-timed write cycle starts when select rises on a valid boundary.
// - Active flag is 1 during the cycle; at its end active and latch clear.
// - Status register stays readable while a write cycle runs.
// - Lock bit 0: latch may be set, lock and protect bits writable.
// - Lock bit 1 and lock pin high: latch settable, bits still writable.
// - Lock bit 1 and lock pin low: every register write is rejected.
// - Pin lock mode is lock bit 1 with lock pin low, either order.
// - Pin lock mode ends only when the lock pin goes high or four-lane command mode or four-lane enable turns on.
// - Four-lane command mode or four-lane enable disables pin lock mode.
// - Program/erase aimed at the protected area is refused in both modes.
// - Origin bit, setup bit3, one-time programmable; 0 top, 1 bottom. Here reset clears it.
// - Drive level bits 2..0 volatile, default 111; codes 000 and 100 reserved.
// - Wait select bit7 picks quad read dummy count: 1 gives 8, 0 gives 6.
// - Lock bit and protect bits default to 0, whole array unprotected.
// - Four-lane enable 0 keeps the lock pin function active unless four-lane command mode is on.

package sflash_pkg;

	// ------------------------------------------------------------
	// Command opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_REGS = 8'h01;
	localparam logic [7:0] OP_LATCH_CLR = 8'h04;
	localparam logic [7:0] OP_READ_STATE = 8'h05;
	localparam logic [7:0] OP_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_READ_SETUP = 8'h15;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int LOCK_POS = 7;
	localparam int FOUR_LANE_POS = 6;
	localparam int PROTECT_MSB = 5;
	localparam int PROTECT_LSB = 2;
	localparam int LATCH_POS = 1;
	localparam int ACTIVE_POS = 0;
	localparam int WAIT_SEL_POS = 7;
	localparam int ORIGIN_POS = 3;
	localparam int DRIVE_MSB = 2;
	localparam int DRIVE_LSB = 0;

	// ------------------------------------------------------------
	// Reset values and encodings
	// ------------------------------------------------------------
	localparam logic [3:0] PROTECT_RESET = 4'h0;
	localparam logic LOCK_RESET = 1'b0;
	localparam logic FOUR_LANE_RESET = 1'b0;
	localparam logic ORIGIN_RESET = 1'b0;
	localparam logic WAIT_SEL_RESET = 1'b0;
	localparam logic [2:0] DRIVE_RESET = 3'h7;
	localparam logic [2:0] DRIVE_RSVD_A = 3'h0;
	localparam logic [2:0] DRIVE_RSVD_B = 3'h4;
	localparam logic [3:0] DUMMY_LONG = 4'h8;
	localparam logic [3:0] DUMMY_SHORT = 4'h6;
	localparam logic [4:0] FRAME_SHORT = 5'h08;
	localparam logic [4:0] FRAME_LONG = 5'h10;
	localparam logic [4:0] FRAME_SAT = 5'h11;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 10;
	localparam int REG_WRITE_TIME_US = 40;
	localparam logic [15:0] REG_WRITE_CYCLES = 16'(REG_WRITE_TIME_US * CLK_MHZ);

	// ------------------------------------------------------------
	// Link frame states, Gray along idle-cmd-data
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CMD = 2'h1,
		ST_DATA = 2'h3,
		ST_OUT = 2'h2
	} link_state_e;

endpackage : sflash_pkg

// file: sflash_regs.sv
// Status and setup register logic of a serial flash, single-lane command path.
// Assumes a host drives select, serial clock and data in clock mode 0; the
// array program/erase engine and protected-area map sit outside.
`timescale 1ns/10ps
module sflash_regs
	import sflash_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic si,
	output logic so,
	output logic so_oe,
	input wire logic lock_pin_n,
	input wire logic four_lane_cmd_mode,
	input wire logic pe_req,
	input wire logic pe_hits_area,
	output logic pe_accept,
	output logic pe_refuse,
	output logic [7:0] device_state_flags,
	output logic [7:0] device_setup_flags,
	output logic pin_lock_mode,
	output logic soft_lock_mode,
	output logic [3:0] quad_io_read_dummy,
	output logic lock_pin_active
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic cs_n_s;
	logic sclk_s;
	logic si_s;
	logic lock_pin_n_s;

	sflash_sync3 #(.RESET_VAL(1'b1)) u_sync_cs (
		.clk(clk),
		.rstn(rstn),
		.d(cs_n),
		.q(cs_n_s)
	);

	sflash_sync3 #(.RESET_VAL(1'b0)) u_sync_sclk (
		.clk(clk),
		.rstn(rstn),
		.d(sclk),
		.q(sclk_s)
	);

	sflash_sync3 #(.RESET_VAL(1'b0)) u_sync_si (
		.clk(clk),
		.rstn(rstn),
		.d(si),
		.q(si_s)
	);

	sflash_sync3 #(.RESET_VAL(1'b1)) u_sync_lock (
		.clk(clk),
		.rstn(rstn),
		.d(lock_pin_n),
		.q(lock_pin_n_s)
	);

	// ------------------------------------------------------------
	// Edge detection
	// ------------------------------------------------------------
	logic sclk_prev_q;
	logic cs_prev_q;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclk_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_s;
			cs_prev_q <= cs_n_s;
		end
	end

	// Clock edges only count inside a frame
	assign sclk_rise = sclk_s && !sclk_prev_q && !cs_n_s;
	assign sclk_fall = !sclk_s && sclk_prev_q && !cs_n_s;
	assign cs_fall = !cs_n_s && cs_prev_q;
	assign cs_rise = cs_n_s && !cs_prev_q;

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic lock_bit_q;
	logic four_lane_enable_q;
	logic [3:0] protect_level_q;
	logic write_latch_flag_q;
	logic write_cycle_active;
	logic protect_origin_bit_q;
	logic [2:0] drive_level_bits_q;
	logic wait_count_select_q;

	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------
	function automatic logic is_read_op(input logic [7:0] op);
		is_read_op = (op == OP_READ_STATE) || (op == OP_READ_SETUP);
	endfunction : is_read_op

	function automatic logic drive_code_ok(input logic [2:0] code);
		drive_code_ok = (code != DRIVE_RSVD_A) && (code != DRIVE_RSVD_B);
	endfunction : drive_code_ok

	// ------------------------------------------------------------
	// Protection modes
	// ------------------------------------------------------------
	logic lock_feature_on;

	// Quad use of the pin takes it away from the lock function
	assign lock_feature_on = !four_lane_enable_q && !four_lane_cmd_mode;
	// Level term: holds in either order and drops only with the pin or feature
	assign pin_lock_mode = lock_feature_on && lock_bit_q && !lock_pin_n_s;
	assign soft_lock_mode = !pin_lock_mode;
	assign lock_pin_active = lock_feature_on;

	// ------------------------------------------------------------
	// Frame decoder
	// ------------------------------------------------------------
	link_state_e st_q;
	logic [2:0] op_cnt_q;
	logic [7:0] op_sh_q;
	logic [7:0] op_q;
	logic [4:0] data_cnt_q;
	logic [15:0] data_sh_q;
	logic [7:0] op_full;

	assign op_full = {op_sh_q[6:0], si_s};

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= ST_IDLE;
		end else if (cs_rise || cs_n_s) begin
			st_q <= ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (cs_fall) begin
						st_q <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (sclk_rise && op_cnt_q == 3'h7) begin
						st_q <= is_read_op(op_full) ? ST_OUT : ST_DATA;
					end
				end
				ST_DATA: st_q <= ST_DATA;
				ST_OUT: st_q <= ST_OUT;
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Opcode capture, MSB first on rising serial clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			op_cnt_q <= 3'h0;
			op_sh_q <= 8'h00;
			op_q <= 8'h00;
		end else if (cs_fall) begin
			op_cnt_q <= 3'h0;
			op_q <= 8'h00;
		end else if (st_q == ST_CMD && sclk_rise) begin
			op_sh_q <= op_full;
			op_cnt_q <= op_cnt_q + 3'h1;
			if (op_cnt_q == 3'h7) begin
				op_q <= op_full;
			end
		end
	end

	// Data bits after the opcode; count saturates so long frames stay invalid
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			data_cnt_q <= 5'h00;
			data_sh_q <= 16'h0000;
		end else if (cs_fall) begin
			data_cnt_q <= 5'h00;
		end else if (st_q == ST_DATA && sclk_rise) begin
			data_sh_q <= {data_sh_q[14:0], si_s};
			if (data_cnt_q != FRAME_SAT) begin
				data_cnt_q <= data_cnt_q + 5'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Command execution at select rise
	// ------------------------------------------------------------
	logic frame_ok;
	logic frame_long;
	logic latch_set_go;
	logic latch_clr_go;
	logic write_regs_go;

	assign frame_long = (data_cnt_q == FRAME_LONG);
	assign frame_ok = (data_cnt_q == FRAME_SHORT) || frame_long;
	assign latch_set_go = cs_rise && st_q == ST_DATA && op_q == OP_LATCH_SET
		&& data_cnt_q == 5'h00 && !write_cycle_active;
	assign latch_clr_go = cs_rise && st_q == ST_DATA && op_q == OP_LATCH_CLR
		&& data_cnt_q == 5'h00 && !write_cycle_active;
	// Refused silently without the latch, in pin lock or while busy
	assign write_regs_go = cs_rise && st_q == ST_DATA && op_q == OP_WRITE_REGS
		&& frame_ok && write_latch_flag_q && !pin_lock_mode
		&& !write_cycle_active;

	// ------------------------------------------------------------
	// Write cycle
	// ------------------------------------------------------------
	logic cycle_done;
	logic timer_busy;
	logic [7:0] pend_state_q;
	logic [7:0] pend_setup_q;
	logic pend_long_q;

	sflash_write_timer u_timer (
		.clk(clk),
		.rstn(rstn),
		.start(write_regs_go),
		.busy(timer_busy),
		.done(cycle_done)
	);

	// Flag spans the commit cycle so it drops with the latch and new fields
	assign write_cycle_active = timer_busy || cycle_done;

	// Data held until the cycle ends so a read sees old values meanwhile
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pend_state_q <= 8'h00;
			pend_setup_q <= 8'h00;
			pend_long_q <= 1'b0;
		end else if (write_regs_go) begin
			pend_long_q <= frame_long;
			if (frame_long) begin
				pend_state_q <= data_sh_q[15:8];
				pend_setup_q <= data_sh_q[7:0];
			end else begin
				pend_state_q <= data_sh_q[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Status fields
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lock_bit_q <= LOCK_RESET;
			four_lane_enable_q <= FOUR_LANE_RESET;
			protect_level_q <= PROTECT_RESET;
		end else if (cycle_done) begin
			lock_bit_q <= pend_state_q[LOCK_POS];
			four_lane_enable_q <= pend_state_q[FOUR_LANE_POS];
			protect_level_q <= pend_state_q[PROTECT_MSB:PROTECT_LSB];
		end
	end

	// Latch and active bits never come from written data
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			write_latch_flag_q <= 1'b0;
		end else if (latch_set_go) begin
			write_latch_flag_q <= 1'b1;
		end else if (latch_clr_go || cycle_done) begin
			write_latch_flag_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Setup fields
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			protect_origin_bit_q <= ORIGIN_RESET;
			drive_level_bits_q <= DRIVE_RESET;
			wait_count_select_q <= WAIT_SEL_RESET;
		end else if (cycle_done && pend_long_q) begin
			// One-time bit: a write can only set it; only reset clears it
			protect_origin_bit_q <= protect_origin_bit_q | pend_setup_q[ORIGIN_POS];
			wait_count_select_q <= pend_setup_q[WAIT_SEL_POS];
			if (drive_code_ok(pend_setup_q[DRIVE_MSB:DRIVE_LSB])) begin
				drive_level_bits_q <= pend_setup_q[DRIVE_MSB:DRIVE_LSB];
			end
		end
	end

	assign quad_io_read_dummy = wait_count_select_q ? DUMMY_LONG : DUMMY_SHORT;

	// ------------------------------------------------------------
	// Register images
	// ------------------------------------------------------------
	logic [7:0] state_img;
	logic [7:0] setup_img;

	always_comb begin
		state_img = 8'h00;
		state_img[LOCK_POS] = lock_bit_q;
		state_img[FOUR_LANE_POS] = four_lane_enable_q;
		state_img[PROTECT_MSB:PROTECT_LSB] = protect_level_q;
		state_img[LATCH_POS] = write_latch_flag_q;
		state_img[ACTIVE_POS] = write_cycle_active;
	end

	always_comb begin
		setup_img = 8'h00;
		setup_img[WAIT_SEL_POS] = wait_count_select_q;
		setup_img[ORIGIN_POS] = protect_origin_bit_q;
		setup_img[DRIVE_MSB:DRIVE_LSB] = drive_level_bits_q;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			device_state_flags <= 8'h00;
			device_setup_flags <= 8'h00;
		end else begin
			device_state_flags <= state_img;
			device_setup_flags <= setup_img;
		end
	end

	// ------------------------------------------------------------
	// Read-out path
	// ------------------------------------------------------------
	logic [2:0] out_bit_q;
	logic [7:0] read_byte;

	// Live image each bit so polling sees the active flag drop mid-frame
	assign read_byte = (op_q == OP_READ_SETUP) ? setup_img : state_img;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_bit_q <= 3'h0;
			so <= 1'b0;
		end else if (cs_fall) begin
			out_bit_q <= 3'h0;
		end else if (st_q == ST_OUT && sclk_fall) begin
			so <= read_byte[3'h7 - out_bit_q];
			out_bit_q <= out_bit_q + 3'h1;
		end
	end

	assign so_oe = (st_q == ST_OUT);

	// ------------------------------------------------------------
	// Program/erase gate
	// ------------------------------------------------------------
	logic pe_blocked;

	// Area match comes from the external map of level and origin
	assign pe_blocked = pe_hits_area && (protect_level_q != PROTECT_RESET);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pe_accept <= 1'b0;
			pe_refuse <= 1'b0;
		end else begin
			pe_accept <= pe_req && write_latch_flag_q && !write_cycle_active && !pe_blocked;
			pe_refuse <= pe_req && !(write_latch_flag_q && !write_cycle_active && !pe_blocked);
		end
	end

endmodule : sflash_regs

// file: sflash_regs_chk.sv
// Checker of the status/setup register block, seen at its ports.
// Assumes one clock domain; bound to every sflash_regs at the foot.
`timescale 1ns/10ps
module sflash_regs_chk
	import sflash_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic lock_pin_n,
	input wire logic four_lane_cmd_mode,
	input wire logic pe_req,
	input wire logic pe_hits_area,
	input wire logic pe_accept,
	input wire logic pe_refuse,
	input wire logic [7:0] device_state_flags,
	input wire logic [7:0] device_setup_flags,
	input wire logic pin_lock_mode,
	input wire logic soft_lock_mode,
	input wire logic [3:0] quad_io_read_dummy
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	logic [9:0] run_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run_q <= 10'h000;
		end else if (device_state_flags[0]) begin
			run_q <= run_q + 10'h001;
		end else begin
			run_q <= 10'h000;
		end
	end
	sequence s_armed;
		device_state_flags[7] && !device_state_flags[6] && !four_lane_cmd_mode && !lock_pin_n;
	endsequence
	sequence s_cycle_end;
		device_state_flags[0] ##1 !device_state_flags[0];
	endsequence
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	// Pin is synchronised, so allow a few cycles either way
	property p_lock_enter; s_armed [*6] |-> pin_lock_mode; endproperty
	a_lock_enter: assert property (p_lock_enter) else $error("pin lock missing");
	property p_lock_exit; lock_pin_n [*6] |-> !pin_lock_mode; endproperty
	a_lock_exit: assert property (p_lock_exit) else $error("pin lock held");
	property p_lane_off; four_lane_cmd_mode || device_state_flags[6] |-> !pin_lock_mode; endproperty
	a_lane_off: assert property (p_lane_off) else $error("pin lock with four lanes");
	property p_soft; soft_lock_mode == !pin_lock_mode; endproperty
	a_soft: assert property (p_soft) else $error("lock modes disagree");
	property p_frozen; pin_lock_mode && !device_state_flags[0] |=> $stable(device_state_flags[7:2]); endproperty
	a_frozen: assert property (p_frozen) else $error("write in pin lock");
	property p_end_clears; s_cycle_end |-> !device_state_flags[1]; endproperty
	a_end_clears: assert property (p_end_clears) else $error("latch kept");
	property p_start_latched; !device_state_flags[0] ##1 device_state_flags[0] |-> device_state_flags[1]; endproperty
	a_start_latched: assert property (p_start_latched) else $error("write without latch");
	property p_cycle_len; s_cycle_end |-> run_q >= 10'h190 && run_q <= 10'h192; endproperty
	a_cycle_len: assert property (p_cycle_len) else $error("write cycle length");
	// Image lags the live field by a cycle, so look one back
	property p_dummy; device_setup_flags[7] [*3] |-> $past(quad_io_read_dummy) == DUMMY_LONG; endproperty
	a_dummy: assert property (p_dummy) else $error("dummy count");
	property p_pe_one; pe_req |=> pe_accept != pe_refuse; endproperty
	a_pe_one: assert property (p_pe_one) else $error("pe answer");
	property p_pe_prot; pe_req && pe_hits_area && device_state_flags[5:2] != 4'h0 |=> pe_refuse; endproperty
	a_pe_prot: assert property (p_pe_prot) else $error("protected pe taken");
endmodule : sflash_regs_chk

bind sflash_regs sflash_regs_chk u_chk (
	.clk(clk),
	.rstn(rstn),
	.lock_pin_n(lock_pin_n),
	.four_lane_cmd_mode(four_lane_cmd_mode),
	.pe_req(pe_req),
	.pe_hits_area(pe_hits_area),
	.pe_accept(pe_accept),
	.pe_refuse(pe_refuse),
	.device_state_flags(device_state_flags),
	.device_setup_flags(device_setup_flags),
	.pin_lock_mode(pin_lock_mode),
	.soft_lock_mode(soft_lock_mode),
	.quad_io_read_dummy(quad_io_read_dummy)
);

// file: sflash_sync3.sv
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the input is asynchronous to clk.
`timescale 1ns/10ps
module sflash_sync3 #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic d,
	output logic q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Change accepted only once two settled stages agree
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= RESET_VAL;
		end else if (s2_q == s3_q) begin
			q <= s3_q;
		end
	end
endmodule : sflash_sync3

// file: sflash_write_timer.sv
// Self-timed register write cycle counter.
// Assumes start is a one-cycle pulse and is not raised while busy.
`timescale 1ns/10ps
module sflash_write_timer
	import sflash_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	output logic busy,
	output logic done
);
	logic [15:0] cnt_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 16'h0000;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				cnt_q <= REG_WRITE_CYCLES - 16'h0001;
				busy <= 1'b1;
			end else if (busy) begin
				if (cnt_q == 16'h0000) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end
		end
	end
endmodule : sflash_write_timer

// file: tb.sv
// Self-checking bench: host model on the link, bench on pins and pe.
// Assumes the checker binds itself to sflash_regs.
`timescale 1ns/10ps
module tb
	import sflash_pkg::*;
;
	logic clk, rstn, lock_pin_n, fl_mode, pe_req, pe_hit;
	logic cs_n, sclk, si, so, so_oe, pe_accept, pe_refuse, pl, sl, lpa;
	logic [7:0] st, sc;
	logic [3:0] dum, p, q;
	logic [7:0] exp_q[$];
	int miscompares, check_count;
	sflash_host u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe));
	sflash_regs u_dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe),
		.lock_pin_n(lock_pin_n), .four_lane_cmd_mode(fl_mode), .pe_req(pe_req), .pe_hits_area(pe_hit),
		.pe_accept(pe_accept), .pe_refuse(pe_refuse), .device_state_flags(st), .device_setup_flags(sc),
		.pin_lock_mode(pl), .soft_lock_mode(sl), .quad_io_read_dummy(dum), .lock_pin_active(lpa));
	// ------------------------------------------------------------
	// Checking
	// ------------------------------------------------------------
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	always @(u_host.rd_ev) cmp(u_host.rd_q, exp_q.pop_front());
	always @(posedge clk) if (pe_accept === 1'b1 || pe_refuse === 1'b1) cmp({6'h00, pe_accept, pe_refuse}, exp_q.pop_front());
	task report_and_stop;
		if (exp_q.size() != 0) miscompares++;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	task automatic latch();
		u_host.xfer(OP_LATCH_SET, 16'h0000, 0);
	endtask : latch
	task automatic rd(input logic [7:0] o, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.xfer(o, 16'h0000, 8);
	endtask : rd
	task automatic settle();
		repeat (10) @(posedge clk);
		for (int i = 0; i < 500 && st[0] !== 1'b0; i++) @(posedge clk);
		#1;
	endtask : settle
	task automatic pe(input logic h, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		#1 pe_req = 1'b1;
		pe_hit = h;
		@(posedge clk);
		#1 pe_req = 1'b0;
		repeat (2) @(posedge clk);
	endtask : pe
	task automatic pins(input logic [7:0] e);
		repeat (8) @(posedge clk);
		cmp({5'h00, lpa, sl, pl}, e);
	endtask : pins
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#4000000;
		miscompares++;
		report_and_stop();
	end
	initial begin
		rstn = 1'b0;
		lock_pin_n = 1'b1;
		fl_mode = 1'b0;
		pe_req = 1'b0;
		pe_hit = 1'b0;
		void'($urandom(20479));
		p = 4'($urandom % 15 + 1);
		q = 4'($urandom % 15 + 1);
		repeat (6) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (6) @(posedge clk);
		cmp(st, 8'h00);
		cmp(sc, 8'h07);
		cmp({4'h0, dum}, 8'h06);
		rd(OP_READ_SETUP, 8'h07);
		u_host.xfer(OP_WRITE_REGS, 16'h3C00, 8);
		settle();
		cmp(st, 8'h00);
		latch();
		cmp(st, 8'h02);
		u_host.xfer(OP_WRITE_REGS, {2'b00, p, 2'b11, 8'h8D}, 16);
		rd(OP_READ_STATE, 8'h03);
		settle();
		cmp(st, {2'b00, p, 2'b00});
		cmp(sc, 8'h8D);
		cmp({4'h0, dum}, 8'h08);
		latch();
		u_host.xfer(OP_WRITE_REGS, 16'hFFFF, 12);
		settle();
		cmp(st, {2'b00, p, 2'b10});
		u_host.xfer(OP_WRITE_REGS, {2'b10, q, 2'b00, 8'h00}, 8);
		settle();
		cmp(st, {2'b10, q, 2'b00});
		cmp(sc, 8'h8D);
		pe(1'b1, 8'h01);
		pe(1'b0, 8'h01);
		latch();
		pe(1'b0, 8'h02);
		u_host.xfer(OP_LATCH_CLR, 16'h0000, 0);
		cmp(st, {2'b10, q, 2'b00});
		latch();
		#1 lock_pin_n = 1'b0;
		pins(8'h05);
		u_host.xfer(OP_WRITE_REGS, {2'b00, p, 2'b00, 8'h00}, 16);
		settle();
		cmp(st, {2'b10, q, 2'b10});
		pe(1'b1, 8'h01);
		#1 fl_mode = 1'b1;
		pins(8'h02);
		#1 fl_mode = 1'b0;
		lock_pin_n = 1'b1;
		pins(8'h06);
		u_host.xfer(OP_WRITE_REGS, 16'h4000, 16);
		settle();
		cmp(st, 8'h40);
		cmp(sc, 8'h0D);
		cmp({4'h0, dum}, 8'h06);
		#1 lock_pin_n = 1'b0;
		pins(8'h02);
		#1 rstn = 1'b0;
		repeat (2) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (2) @(posedge clk);
		cmp(st, 8'h00);
		cmp(sc, 8'h07);
		report_and_stop();
	end
endmodule : tb
